// File: include/rdcfg_if.sv
// Serial control link and control pins between host and re-driver
`timescale 1ns/1ps
`default_nettype none
interface rdcfg_if;
  // Open-drain drivers: enable high pulls the wire to the output level
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  // Plain control pins driven by the host
  logic reset_bar_input;
  logic dev_enable;
  // Resolved wire levels, pulled up when nobody drives low
  logic scl_line;
  logic sda_line;
  assign scl_line = ~(host_scl_oe & ~host_scl_o);
  assign sda_line = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

  modport host (
    output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, reset_bar_input, dev_enable,
    input scl_line, sda_line
  );
  modport device (
    output dev_sda_o, dev_sda_oe,
    input scl_line, sda_line, reset_bar_input, dev_enable
  );
endinterface
`default_nettype wire

// File: include/rdcfg_pkg.sv
// Shared constants and types for the re-driver configuration and mode control
package rdcfg_pkg;
  // Clock rate and derived cycle scale
  localparam int MCLK_HZ = 10_000_000;
  localparam int CYC_PER_US = MCLK_HZ / 1_000_000;
  localparam int CYC_PER_MS = MCLK_HZ / 1_000;

  // Slave addresses selected by the address strap
  localparam logic [6:0] SLV_ADDR_LOW = 7'h2c;
  localparam logic [6:0] SLV_ADDR_MID = 7'h2d;
  localparam logic [6:0] SLV_ADDR_HIGH = 7'h2e;
  // Strap level codes as delivered by the pin comparator
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_MID = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;

  // Register offsets
  localparam logic [7:0] REG_SQUELCH = 8'h03;
  localparam logic [7:0] REG_ADJUST = 8'h04;
  localparam logic [7:0] REG_GAIN0 = 8'h05;
  localparam logic [7:0] REG_GAIN1 = 8'h07;
  localparam logic [7:0] REG_GAIN2 = 8'h09;
  localparam logic [7:0] REG_GAIN3 = 8'h0b;
  // Field positions
  localparam int ADJ_SEL_BIT = 2;
  localparam int GAIN_EN_BIT = 7;
  localparam int SQ_DIS_BIT = 3;
  localparam int SQ_THR_LSB = 4;
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 3;
  // Values after reset
  localparam logic [7:0] RST_SQUELCH = 8'h10;
  localparam logic [7:0] RST_ADJUST = 8'h04;
  localparam logic [7:0] RST_GAIN = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Times in their own units
  localparam int SQ_ENTER_MIN_US = 10;
  localparam int SQ_ENTER_MAX_US = 120;
  localparam int SQ_EXIT_MAX_US = 1;
  localparam int RST_HOLD_MIN_US = 100;
  localparam int AVAIL_MIN_MS = 400;
  localparam int SCL_KHZ = 100;
  // Cycle counts (rates divide exactly, so no rounding is lost)
  localparam int SQ_ENTER_CYC = SQ_ENTER_MIN_US * CYC_PER_US;
  localparam int SQ_EXIT_CYC = SQ_EXIT_MAX_US * CYC_PER_US;
  localparam int RST_HOLD_CYC = RST_HOLD_MIN_US * CYC_PER_US;
  localparam int AVAIL_CYC = AVAIL_MIN_MS * CYC_PER_MS;
  localparam int SCL_QTR_CYC = MCLK_HZ / (SCL_KHZ * 1000 * 4);
  localparam int STRAP_SETTLE_CYC = 3;

  // Device serial engine states
  typedef enum logic [8:0] {
    DS_IDLE = 9'h001, DS_ADDR = 9'h002, DS_ACK_A = 9'h004,
    DS_OFFS = 9'h008, DS_ACK_O = 9'h010, DS_WDAT = 9'h020,
    DS_ACK_W = 9'h040, DS_RDAT = 9'h080, DS_RACK = 9'h100
  } rdcfg_dstate_t;
  // Device operating modes
  typedef enum logic [2:0] {
    MODE_SHUTDOWN = 3'h1, MODE_ACTIVE = 3'h2, MODE_SQUELCH = 3'h4
  } rdcfg_mode_t;
  // Host sequencer states
  typedef enum logic [5:0] {
    HS_BOOT = 6'h01, HS_WAIT = 6'h02, HS_IDLE = 6'h04,
    HS_START = 6'h08, HS_BIT = 6'h10, HS_STOP = 6'h20
  } rdcfg_hstate_t;
endpackage

// File: sim/rdcfg_asserts.sv
// Checker for mode sequencing and serial pin timing
`timescale 1ns/1ps
`default_nettype none
module rdcfg_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link pins
  input wire logic reset_bar_input,
  input wire logic dev_enable,
  input wire logic scl_line,
  input wire logic dev_sda_oe,
  // Device side
  input wire logic signal_valid,
  input wire logic squelch_disable,
  input wire logic main_video_lanes_on,
  input wire logic [2:0] dev_mode
);
  // Both control pins high
  wire up = reset_bar_input & dev_enable;
  // Cycles since input loss; saturates so a long loss never wraps
  logic [10:0] lost_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Loss counter
  always_ff @(posedge mclk or posedge rst)
    if (rst) lost_q <= '0;
    else if (signal_valid) lost_q <= '0;
    else if (lost_q != 11'h7ff) lost_q <= lost_q + 11'h1;
  AST_SHDN: assert property (!up |-> ##[1:3] dev_mode == 3'h1)
    else $error("no shutdown");
  AST_ACTIVE: assert property ((up && signal_valid) [*8] |-> main_video_lanes_on && dev_mode == 3'h2)
    else $error("not active");
  AST_SQ_OFF: assert property (dev_mode == 3'h4 |-> !main_video_lanes_on)
    else $error("lanes on in squelch");
  AST_SQ_MIN: assert property ($rose(dev_mode == 3'h4) |-> lost_q >= 11'h064)
    else $error("squelch too early");
  AST_SQ_MAX: assert property (up && !squelch_disable && lost_q == 11'h4b0 |-> !main_video_lanes_on)
    else $error("squelch too late");
  AST_SQ_EXIT: assert property (dev_mode == 3'h4 && signal_valid |-> ##[1:10] main_video_lanes_on)
    else $error("slow squelch exit");
  AST_SQ_DIS: assert property ((up && squelch_disable) [*8] |-> main_video_lanes_on)
    else $error("lanes off while disabled");
  AST_SDA: assert property ($changed(dev_sda_oe) |-> !scl_line)
    else $error("data moved with clock high");
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench joining host and re-driver ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; $display("mismatch %0t %h %h", $time, a, e); end end
module testbench;
  // Stimulus
  logic mclk = 0, rst = 1, enable_req = 1, signal_valid = 1, cmd_valid = 0, cmd_read = 0;
  logic [6:0] cmd_addr = '0;
  logic [7:0] cmd_offset = '0, cmd_wdata = '0;
  logic [1:0] strap = '0;
  // Observed outputs
  logic cmd_ready, rsp_valid, rsp_nack, lanes_on, sq_dis, adj, gen;
  logic [7:0] rsp_rdata;
  logic [2:0] g0, g1, g2, g3, mode;
  logic [1:0] sq_thr;
  int failures = 0, checked = 0, cyc = 0;
  // Notes of {read, nack, data}
  logic [9:0] exp_q [$];
  logic [2:0] g [4];
  logic [6:0] adr [3] = '{rdcfg_pkg::SLV_ADDR_LOW, rdcfg_pkg::SLV_ADDR_MID, rdcfg_pkg::SLV_ADDR_HIGH};
  rdcfg_if link ();
  rdcfg_host #(.AVAIL_CYCLES(50)) u_rdcfg_host (.mclk, .rst, .link(link), .enable_req, .cmd_valid, .cmd_read,
    .cmd_addr, .cmd_offset, .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_nack);
  rdcfg_device u_rdcfg_device (.mclk, .rst, .link(link), .addr_strap_lvl(strap), .signal_valid,
    .rx_gain_code_ch0(g0), .rx_gain_code_ch1(g1), .rx_gain_code_ch2(g2), .rx_gain_code_ch3(g3),
    .host_gain_control_enable(gen), .adjust_by_host(adj), .squelch_threshold(sq_thr),
    .squelch_disable(sq_dis), .main_video_lanes_on(lanes_on), .dev_mode(mode));
  rdcfg_asserts u_rdcfg_asserts (.mclk, .rst, .reset_bar_input(link.reset_bar_input),
    .dev_enable(link.dev_enable), .scl_line(link.scl_line), .dev_sda_oe(link.dev_sda_oe),
    .signal_valid, .squelch_disable(sq_dis), .main_video_lanes_on(lanes_on), .dev_mode(mode));
  // 10 MHz clock
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  // Verdict and end of run
  task automatic summarize();
    if (failures == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One frame; blocks until its response is compared
  task automatic cmd(input logic rd, input logic [6:0] a, input logic [7:0] o, d, input logic [9:0] e);
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b1;
    {cmd_read, cmd_addr, cmd_offset, cmd_wdata} <= {rd, a, o, d};
    exp_q.push_back(e);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    while (exp_q.size() != 0) @(posedge mclk);
  endtask
  // Oldest note against each response
  always @(posedge mclk)
    if (rsp_valid === 1'b1)
    begin
      `CHK(rsp_nack, exp_q[0][8])
      if (exp_q[0][9]) `CHK(rsp_rdata, exp_q[0][7:0])
      void'(exp_q.pop_front());
    end
  // Hang guard, well above the expected run length
  always @(posedge mclk)
    if (++cyc > 100000)
    begin
      failures++;
      summarize();
    end
  // Main sequence: every strap level, then squelch and shutdown
  initial
  begin
    void'($urandom(75));
    for (int s = 0; s < 3; s++)
    begin
      strap <= s[1:0];
      rst <= 1'b1;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      `CHK({sq_thr, sq_dis, adj}, 4'h4)
      cmd(0, adr[(s + 1) % 3], 8'h04, 8'h00, 10'h100);
      cmd(0, adr[s], 8'h04, 8'h00, 10'h000);
      `CHK(adj, 1'b1)
      // Gain control enable goes in alone before any lane code
      cmd(0, adr[s], 8'h05, 8'h80, 10'h000);
      `CHK({gen, g0}, 4'h8)
      foreach (g[i])
      begin
        g[i] = 3'($urandom);
        cmd(0, adr[s], 8'(5 + 2 * i), {i == 0, 4'h0, g[i]}, 10'h000);
      end
      `CHK({gen, g3, g2, g1, g0}, {1'b1, g[3], g[2], g[1], g[0]})
      cmd(1, adr[s], 8'h0b, 8'h00, {2'b10, 5'h00, g[3]});
    end
    signal_valid <= 1'b0;
    repeat (1300) @(posedge mclk);
    `CHK({lanes_on, mode}, 4'h4)
    signal_valid <= 1'b1;
    repeat (10) @(posedge mclk);
    `CHK({lanes_on, mode}, 4'ha)
    cmd(0, adr[2], 8'h03, 8'h18, 10'h000);
    signal_valid <= 1'b0;
    repeat (1300) @(posedge mclk);
    `CHK({lanes_on, sq_dis}, 2'h3)
    enable_req <= 1'b0;
    repeat (5) @(posedge mclk);
    `CHK({lanes_on, mode}, 4'h1)
    summarize();
  end
endmodule
`default_nettype wire

// File: verilog/rdcfg_device.sv
// Re-driver end: serial register bank, gain codes and mode sequencing
`timescale 1ns/1ps
`default_nettype none
module rdcfg_device (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link to the host
  rdcfg_if.device link,
  // Analog side inputs
  input wire logic [1:0] addr_strap_lvl,
  input wire logic signal_valid,
  // Gain settings to the equalizers
  output logic [2:0] rx_gain_code_ch0,
  output logic [2:0] rx_gain_code_ch1,
  output logic [2:0] rx_gain_code_ch2,
  output logic [2:0] rx_gain_code_ch3,
  output logic host_gain_control_enable,
  output logic adjust_by_host,
  // Squelch settings to the detector
  output logic [1:0] squelch_threshold,
  output logic squelch_disable,
  // Mode and driver state
  output logic main_video_lanes_on,
  output logic [2:0] dev_mode
);
  // Whole state of the end
  typedef struct packed {
    rdcfg_pkg::rdcfg_dstate_t st;
    logic [3:0] bcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic scl_p;
    logic sda_p;
    logic sda_oe;
    logic [6:0] own_addr;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [7:0] r_sq;
    logic [7:0] r_adj;
    logic [7:0] r_g0;
    logic [7:0] r_g1;
    logic [7:0] r_g2;
    logic [7:0] r_g3;
    rdcfg_pkg::rdcfg_mode_t mode;
    logic [7:0] loss_cnt;
    logic lanes_on;
  } rdcfg_dev_st_t;

  rdcfg_dev_st_t q;
  rdcfg_dev_st_t d;

  // Synchronised pins: scl, sda, reset pin, enable, valid, strap
  logic [6:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic rstb_s;
  logic en_s;
  logic valid_s;
  logic [1:0] strap_s;

  rdcfg_sync #(.W(7)) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({link.scl_line, link.sda_line, link.reset_bar_input, link.dev_enable,
               signal_valid, addr_strap_lvl}),
    .sync_out(pins_s)
  );
  assign {scl_s, sda_s, rstb_s, en_s, valid_s, strap_s} = pins_s;

  // Readback of the byte at an offset; holes read as zero
  function automatic logic [7:0] rd_byte(input rdcfg_dev_st_t s, input logic [7:0] off);
    logic [7:0] v;
    v = rdcfg_pkg::UNMAPPED_RD;
    if (off == rdcfg_pkg::REG_SQUELCH)
      v = s.r_sq;
    else if (off == rdcfg_pkg::REG_ADJUST)
      v = s.r_adj;
    else if (off == rdcfg_pkg::REG_GAIN0)
      v = s.r_g0;
    else if (off == rdcfg_pkg::REG_GAIN1)
      v = s.r_g1;
    else if (off == rdcfg_pkg::REG_GAIN2)
      v = s.r_g2;
    else if (off == rdcfg_pkg::REG_GAIN3)
      v = s.r_g3;
    return v;
  endfunction

  // Line events seen on the synchronised copies
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise = scl_s & ~q.scl_p;
  assign scl_fall = ~scl_s & q.scl_p;
  assign bus_start = scl_s & q.scl_p & q.sda_p & ~sda_s;
  assign bus_stop = scl_s & q.scl_p & ~q.sda_p & sda_s;

  // Next-state logic
  always_comb
  begin
    d = q;
    d.scl_p = scl_s;
    d.sda_p = sda_s;

    // Strap is read three cycles after the reset pin goes high, then frozen
    if (!rstb_s)
    begin
      d.strap_cnt = 2'h0;
      d.strap_done = 1'b0;
    end
    else if (!q.strap_done)
    begin
      if (q.strap_cnt == 2'(rdcfg_pkg::STRAP_SETTLE_CYC - 1))
      begin
        d.strap_done = 1'b1;
        if (strap_s == rdcfg_pkg::STRAP_HIGH)
          d.own_addr = rdcfg_pkg::SLV_ADDR_HIGH;
        else if (strap_s == rdcfg_pkg::STRAP_MID)
          d.own_addr = rdcfg_pkg::SLV_ADDR_MID;
        else
          d.own_addr = rdcfg_pkg::SLV_ADDR_LOW;
      end
      else
        d.strap_cnt = q.strap_cnt + 2'h1;
    end

    // Serial register engine, bit-level on scl edges
    if (!rstb_s || !q.strap_done || bus_stop)
    begin
      // Engine stays quiet until the address is known
      d.st = rdcfg_pkg::DS_IDLE;
      d.sda_oe = 1'b0;
    end
    else if (bus_start)
    begin
      // A repeated start also lands here
      d.st = rdcfg_pkg::DS_ADDR;
      d.bcnt = 4'h0;
      d.sda_oe = 1'b0;
    end
    else
    begin
      case (q.st)
        rdcfg_pkg::DS_ADDR, rdcfg_pkg::DS_OFFS, rdcfg_pkg::DS_WDAT:
        begin
          if (scl_rise)
          begin
            d.shreg = {q.shreg[6:0], sda_s};
            d.bcnt = q.bcnt + 4'h1;
          end
          else if (scl_fall && q.bcnt == 4'h8)
          begin
            d.bcnt = 4'h0;
            d.sda_oe = 1'b1;
            if (q.st == rdcfg_pkg::DS_ADDR)
            begin
              // Foreign address: stay off the wire
              if (q.shreg[7:1] == q.own_addr)
              begin
                d.rw = q.shreg[0];
                d.st = rdcfg_pkg::DS_ACK_A;
              end
              else
              begin
                d.sda_oe = 1'b0;
                d.st = rdcfg_pkg::DS_IDLE;
              end
            end
            else if (q.st == rdcfg_pkg::DS_OFFS)
            begin
              d.ptr = q.shreg;
              d.st = rdcfg_pkg::DS_ACK_O;
            end
            else
            begin
              // Store the data byte; offset moves on for bursts
              d.st = rdcfg_pkg::DS_ACK_W;
              d.ptr = q.ptr + 8'h01;
              if (q.ptr == rdcfg_pkg::REG_SQUELCH)
                d.r_sq = q.shreg;
              else if (q.ptr == rdcfg_pkg::REG_ADJUST)
                d.r_adj = q.shreg;
              else if (q.ptr == rdcfg_pkg::REG_GAIN0)
                d.r_g0 = q.shreg;
              else if (q.ptr == rdcfg_pkg::REG_GAIN1)
                d.r_g1 = q.shreg;
              else if (q.ptr == rdcfg_pkg::REG_GAIN2)
                d.r_g2 = q.shreg;
              else if (q.ptr == rdcfg_pkg::REG_GAIN3)
                d.r_g3 = q.shreg;
            end
          end
        end
        rdcfg_pkg::DS_ACK_A:
        begin
          if (scl_fall)
          begin
            if (q.rw)
            begin
              // Read: first data bit goes out right after the ack
              d.shreg = {rd_byte(q, q.ptr)};
              d.sda_oe = ~d.shreg[7];
              d.shreg = {d.shreg[6:0], 1'b0};
              d.st = rdcfg_pkg::DS_RDAT;
            end
            else
            begin
              d.sda_oe = 1'b0;
              d.st = rdcfg_pkg::DS_OFFS;
            end
          end
        end
        rdcfg_pkg::DS_ACK_O, rdcfg_pkg::DS_ACK_W:
        begin
          if (scl_fall)
          begin
            d.sda_oe = 1'b0;
            d.st = rdcfg_pkg::DS_WDAT;
          end
        end
        rdcfg_pkg::DS_RDAT:
        begin
          if (scl_rise)
            d.bcnt = q.bcnt + 4'h1;
          else if (scl_fall)
          begin
            if (q.bcnt == 4'h8)
            begin
              d.sda_oe = 1'b0;
              d.bcnt = 4'h0;
              d.st = rdcfg_pkg::DS_RACK;
            end
            else
            begin
              d.sda_oe = ~q.shreg[7];
              d.shreg = {q.shreg[6:0], 1'b0};
            end
          end
        end
        rdcfg_pkg::DS_RACK:
        begin
          // Host nack ends the read; ack asks for the next byte
          if (scl_rise)
          begin
            if (sda_s)
              d.st = rdcfg_pkg::DS_IDLE;
            else
              d.ptr = q.ptr + 8'h01;
          end
          else if (scl_fall)
          begin
            d.shreg = rd_byte(q, q.ptr);
            d.sda_oe = ~d.shreg[7];
            d.shreg = {d.shreg[6:0], 1'b0};
            d.st = rdcfg_pkg::DS_RDAT;
          end
        end
        default:
          d.sda_oe = 1'b0;
      endcase
    end

    // Reset pin low returns the bank to its defaults
    if (!rstb_s)
    begin
      d.r_sq = rdcfg_pkg::RST_SQUELCH;
      d.r_adj = rdcfg_pkg::RST_ADJUST;
      d.r_g0 = rdcfg_pkg::RST_GAIN;
      d.r_g1 = rdcfg_pkg::RST_GAIN;
      d.r_g2 = rdcfg_pkg::RST_GAIN;
      d.r_g3 = rdcfg_pkg::RST_GAIN;
    end

    // Mode sequencing
    if (!rstb_s || !en_s)
    begin
      d.mode = rdcfg_pkg::MODE_SHUTDOWN;
      d.lanes_on = 1'b0;
      d.loss_cnt = 8'h00;
    end
    else if (q.r_sq[rdcfg_pkg::SQ_DIS_BIT] || valid_s)
    begin
      // Exit from squelch costs sync plus one cycle, well inside 1 us
      d.mode = rdcfg_pkg::MODE_ACTIVE;
      d.lanes_on = 1'b1;
      d.loss_cnt = 8'h00;
    end
    else if (q.mode != rdcfg_pkg::MODE_SQUELCH)
    begin
      // Lanes stay on until loss has lasted the least entry time
      if (q.loss_cnt == 8'(rdcfg_pkg::SQ_ENTER_CYC - 1))
      begin
        d.mode = rdcfg_pkg::MODE_SQUELCH;
        d.lanes_on = 1'b0;
      end
      else
      begin
        d.mode = rdcfg_pkg::MODE_ACTIVE;
        d.lanes_on = 1'b1;
        d.loss_cnt = q.loss_cnt + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= rdcfg_pkg::DS_IDLE;
      q.scl_p <= 1'b1;
      q.sda_p <= 1'b1;
      q.own_addr <= rdcfg_pkg::SLV_ADDR_LOW;
      q.r_sq <= rdcfg_pkg::RST_SQUELCH;
      q.r_adj <= rdcfg_pkg::RST_ADJUST;
      q.r_g0 <= rdcfg_pkg::RST_GAIN;
      q.r_g1 <= rdcfg_pkg::RST_GAIN;
      q.r_g2 <= rdcfg_pkg::RST_GAIN;
      q.r_g3 <= rdcfg_pkg::RST_GAIN;
      q.mode <= rdcfg_pkg::MODE_SHUTDOWN;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = q.sda_oe;
  assign rx_gain_code_ch0 = q.r_g0[rdcfg_pkg::GAIN_LSB +: rdcfg_pkg::GAIN_W];
  assign rx_gain_code_ch1 = q.r_g1[rdcfg_pkg::GAIN_LSB +: rdcfg_pkg::GAIN_W];
  assign rx_gain_code_ch2 = q.r_g2[rdcfg_pkg::GAIN_LSB +: rdcfg_pkg::GAIN_W];
  assign rx_gain_code_ch3 = q.r_g3[rdcfg_pkg::GAIN_LSB +: rdcfg_pkg::GAIN_W];
  assign host_gain_control_enable = q.r_g0[rdcfg_pkg::GAIN_EN_BIT];
  assign adjust_by_host = ~q.r_adj[rdcfg_pkg::ADJ_SEL_BIT];
  assign squelch_threshold = q.r_sq[rdcfg_pkg::SQ_THR_LSB +: 2];
  assign squelch_disable = q.r_sq[rdcfg_pkg::SQ_DIS_BIT];
  assign main_video_lanes_on = q.lanes_on;
  assign dev_mode = q.mode;
endmodule
`default_nettype wire

// File: verilog/rdcfg_host.sv
// Host end: power-up sequencing and serial register master
`timescale 1ns/1ps
`default_nettype none
module rdcfg_host #(
  parameter int AVAIL_CYCLES = rdcfg_pkg::AVAIL_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Link to the re-driver
  rdcfg_if.host link,
  // Enable request from the user
  input wire logic enable_req,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_addr,
  input wire logic [7:0] cmd_offset,
  input wire logic [7:0] cmd_wdata,
  output logic cmd_ready,
  // Response port
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic rsp_nack
);
  // Whole state of the end
  typedef struct packed {
    rdcfg_pkg::rdcfg_hstate_t st;
    logic [31:0] cnt;
    logic [4:0] div;
    logic [1:0] qph;
    logic [3:0] bitn;
    logic [1:0] step;
    logic [7:0] sh;
    logic [7:0] rx;
    logic ack_bad;
    logic rd;
    logic [6:0] addr;
    logic [7:0] off;
    logic [7:0] wdat;
    logic scl_oe;
    logic sda_oe;
    logic rstb;
    logic en;
    logic ready;
    logic rvalid;
    logic [7:0] rdata;
    logic nack;
  } rdcfg_host_st_t;

  rdcfg_host_st_t q;
  rdcfg_host_st_t d;
  logic sda_s;
  logic tick;

  rdcfg_sync #(.W(1)) u_sda_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in(link.sda_line),
    .sync_out(sda_s)
  );

  // Byte sent at each step of a transfer
  function automatic logic [7:0] byte_of(input rdcfg_host_st_t s, input logic [1:0] stp);
    logic [7:0] b;
    b = 8'hff;
    case (stp)
      2'h0: b = {s.addr, 1'b0};
      2'h1: b = s.off;
      2'h2: b = s.rd ? {s.addr, 1'b1} : s.wdat;
      default: b = 8'hff;
    endcase
    return b;
  endfunction

  // Quarter-period enable for the serial clock
  assign tick = (q.div == 5'(rdcfg_pkg::SCL_QTR_CYC - 1));

  // Next-state logic
  always_comb
  begin
    d = q;
    d.rvalid = 1'b0;
    d.en = enable_req;
    if (q.st == rdcfg_pkg::HS_START || q.st == rdcfg_pkg::HS_BIT || q.st == rdcfg_pkg::HS_STOP)
      d.div = tick ? 5'h00 : q.div + 5'h01;
    else
      d.div = 5'h00;
    if (tick)
      d.qph = q.qph + 2'h1;
    case (q.st)
      rdcfg_pkg::HS_BOOT:
      begin
        // Supplies are taken as good when rst is released
        d.rstb = 1'b0;
        if (q.cnt == 32'(rdcfg_pkg::RST_HOLD_CYC - 1))
        begin
          d.rstb = 1'b1;
          d.cnt = 32'h0000_0000;
          d.st = rdcfg_pkg::HS_WAIT;
        end
        else
          d.cnt = q.cnt + 32'h0000_0001;
      end
      rdcfg_pkg::HS_WAIT:
      begin
        if (q.cnt == 32'(AVAIL_CYCLES - 1))
        begin
          d.ready = 1'b1;
          d.st = rdcfg_pkg::HS_IDLE;
        end
        else
          d.cnt = q.cnt + 32'h0000_0001;
      end
      rdcfg_pkg::HS_IDLE:
      begin
        if (cmd_valid)
        begin
          d.ready = 1'b0;
          d.rd = cmd_read;
          d.addr = cmd_addr;
          d.off = cmd_offset;
          d.wdat = cmd_wdata;
          d.step = 2'h0;
          d.nack = 1'b0;
          d.qph = 2'h0;
          d.st = rdcfg_pkg::HS_START;
        end
      end
      rdcfg_pkg::HS_START:
      begin
        // Works as first or repeated start
        if (tick)
        begin
          case (q.qph)
            2'h0: d.sda_oe = 1'b0;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b1;
            default:
            begin
              d.scl_oe = 1'b1;
              d.bitn = 4'h0;
              d.sh = byte_of(q, q.step);
              d.st = rdcfg_pkg::HS_BIT;
            end
          endcase
        end
      end
      rdcfg_pkg::HS_BIT:
      begin
        if (tick)
        begin
          case (q.qph)
            2'h0: d.sda_oe = (q.bitn != 4'h8) && (q.step != 2'h3) && !q.sh[7];
            2'h1: d.scl_oe = 1'b0;
            2'h2:
            begin
              if (q.bitn == 4'h8)
                d.ack_bad = sda_s;
              else
              begin
                d.rx = {q.rx[6:0], sda_s};
                d.sh = {q.sh[6:0], 1'b1};
              end
            end
            default:
            begin
              d.scl_oe = 1'b1;
              d.bitn = q.bitn + 4'h1;
              if (q.bitn == 4'h8)
              begin
                // Offset first, then data: the order a register access needs
                d.bitn = 4'h0;
                if (q.step != 2'h3 && q.ack_bad)
                begin
                  d.nack = 1'b1;
                  d.st = rdcfg_pkg::HS_STOP;
                end
                else if ((!q.rd && q.step == 2'h2) || q.step == 2'h3)
                  d.st = rdcfg_pkg::HS_STOP;
                else if (q.rd && q.step == 2'h1)
                begin
                  d.step = 2'h2;
                  d.st = rdcfg_pkg::HS_START;
                end
                else
                begin
                  d.step = q.step + 2'h1;
                  d.sh = byte_of(q, q.step + 2'h1);
                end
              end
            end
          endcase
        end
      end
      rdcfg_pkg::HS_STOP:
      begin
        if (tick)
        begin
          case (q.qph)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0;
            default:
            begin
              d.rvalid = 1'b1;
              d.rdata = q.rx;
              d.ready = 1'b1;
              d.st = rdcfg_pkg::HS_IDLE;
            end
          endcase
        end
      end
      default:
        d.st = rdcfg_pkg::HS_BOOT;
    endcase
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.st <= rdcfg_pkg::HS_BOOT;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = q.scl_oe;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = q.sda_oe;
  assign link.reset_bar_input = q.rstb;
  assign link.dev_enable = q.en;
  assign cmd_ready = q.ready;
  assign rsp_valid = q.rvalid;
  assign rsp_rdata = q.rdata;
  assign rsp_nack = q.nack;
endmodule
`default_nettype wire

// File: verilog/rdcfg_sync.sv
// Two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module rdcfg_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Asynchronous input and its safe copy
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // Only the second stage is ever read outside
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } rdcfg_sync_st_t;

  rdcfg_sync_st_t st_q;
  rdcfg_sync_st_t st_d;

  // Shift one stage per clock
  always_comb
  begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.stable = st_q.meta;
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sync_out = st_q.stable;
endmodule
`default_nettype wire
